//--- logic/fwc_host.sv
/*
  host controller that drives a serial flash through select, clock and
  four data lines, in one, two or four lane phases.
  assumes software writes one byte at a time into the write data register
  and pops received bytes from the read data register.
*/
`timescale 1ns/1ps
`default_nettype none
module fwc_host
  import fwc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flash pins
  output logic flash_sel_b,
  output logic flash_sck,
  output logic [3:0] io_line_out,
  output logic [3:0] io_line_oe,
  input wire logic [3:0] io_line_in
);
  // ----------------------------------------
  // state machine
  // ----------------------------------------
  typedef enum logic [5:0] {
    FWC_IDLE  = 6'b000001,
    FWC_CMD   = 6'b000010,
    FWC_ADR   = 6'b000100,
    FWC_DUMMY = 6'b001000,
    FWC_DATA  = 6'b010000,
    FWC_END   = 6'b100000
  } fwc_state_t;

  fwc_state_t state_reg, state_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [23:0] adr_reg, adr_next;
  logic [8:0] len_reg, len_next;
  logic [5:0] lanes_reg, lanes_next;
  logic [7:0] tx_reg, tx_next;
  logic tx_full_reg, tx_full_next;
  logic [7:0] rx_reg, rx_next;
  logic rx_valid_reg, rx_valid_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [31:0] sh_reg, sh_next;
  logic [5:0] bits_reg, bits_next;
  logic [3:0] div_reg, div_next;
  logic sck_reg, sck_next;
  logic sel_b_reg, sel_b_next;
  logic [3:0] out_reg, out_next;
  logic [3:0] oe_reg, oe_next;
  logic [31:0] rdata_reg, rdata_next;
  logic refused_reg, refused_next;
  logic permit_reg, permit_next;
  logic [3:0] in_s1_reg, in_s2_reg, in_s3_reg;

  logic [1:0] lane_mode;
  logic [2:0] step;
  logic rise, fall, stall;
  logic [7:0] op;

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  // second and third agreeing rejects a sample caught mid-transition
  logic [3:0] in_clean_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      in_s1_reg <= 4'h0;
      in_s2_reg <= 4'h0;
      in_s3_reg <= 4'h0;
      in_clean_reg <= 4'h0;
    end else begin
      in_s1_reg <= io_line_in;
      in_s2_reg <= in_s1_reg;
      in_s3_reg <= in_s2_reg;
      in_clean_reg <= (in_s2_reg == in_s3_reg) ? in_s3_reg : in_clean_reg;
    end
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  assign op = ctrl_reg[CTRL_OP_LSB +: 8];
  assign rise = (div_reg == SCK_HALF) && !sck_reg;
  assign fall = (div_reg == SCK_HALF) && sck_reg;
  // hold the low phase on an empty write byte or an unread received byte
  assign stall = (state_reg == FWC_DATA) && (div_reg == 4'h0) && !sck_reg &&
                 (bits_reg == 6'd8) && (ctrl_reg[CTRL_READ] ? rx_valid_reg : !tx_full_reg);

  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    adr_next = adr_reg;
    len_next = len_reg;
    lanes_next = lanes_reg;
    tx_next = tx_reg;
    tx_full_next = tx_full_reg;
    rx_next = rx_reg;
    rx_valid_next = rx_valid_reg;
    rx_sh_next = rx_sh_reg;
    sh_next = sh_reg;
    bits_next = bits_reg;
    div_next = div_reg;
    sck_next = sck_reg;
    sel_b_next = sel_b_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    refused_next = refused_reg;
    permit_next = permit_reg;
    rdata_next = 32'h0000_0000;
    lane_mode = LANE_ONE;
    step = 3'h1;
    case (state_reg)
      FWC_CMD: lane_mode = lanes_reg[LANES_CMD_LSB +: 2];
      FWC_ADR: lane_mode = lanes_reg[LANES_ADR_LSB +: 2];
      FWC_DATA: lane_mode = lanes_reg[LANES_DAT_LSB +: 2];
      default: lane_mode = LANE_ONE;
    endcase
    case (lane_mode)
      LANE_TWO: step = 3'h2;
      LANE_FOUR: step = 3'h4;
      default: step = 3'h1;
    endcase
    // software reads
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: rdata_next = ctrl_reg;
        REG_ADDR: rdata_next = {8'h00, adr_reg};
        REG_LEN: rdata_next = {23'h000000, len_reg};
        REG_RDATA: begin
          rdata_next = {24'h000000, rx_reg};
          rx_valid_next = 1'b0;
        end
        REG_STATUS: rdata_next = {27'h0000000, permit_reg, tx_full_reg, rx_valid_reg, refused_reg,
                                  state_reg != FWC_IDLE};
        REG_LANES: rdata_next = {26'h0000000, lanes_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    // software writes; start is refused for rule-breaking commands
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          if (state_reg == FWC_IDLE) begin
            ctrl_next = reg_wdata;
            ctrl_next[CTRL_GO] = 1'b0;
            refused_next = 1'b0;
            if (reg_wdata[CTRL_GO]) begin
              if (((reg_wdata[7:0] == OP_PAGE_PROGRAM) ||
                   (reg_wdata[7:0] == OP_QUAD_PAGE_PROGRAM) ||
                   (reg_wdata[7:0] == OP_SEC_PROGRAM)) &&
                  ((len_reg == 9'h000) || (len_reg > MAX_PROGRAM_BYTES))) begin
                refused_next = 1'b1;
              end else if (((reg_wdata[7:0] == OP_SEC_PROGRAM) ||
                            (reg_wdata[7:0] == OP_SEC_ERASE)) &&
                           (adr_reg[23:10] != 14'h0000)) begin
                refused_next = 1'b1;
              end else if ((reg_wdata[7:0] == OP_WORD_READ_QIO) && adr_reg[0]) begin
                refused_next = 1'b1;
              end else if ((reg_wdata[7:0] == OP_OCTAL_READ_QIO) &&
                           (adr_reg[3:0] != 4'h0)) begin
                refused_next = 1'b1;
              end else begin
                state_next = FWC_CMD;
                sel_b_next = 1'b0;
                sh_next = {reg_wdata[7:0], 24'h000000};
                bits_next = 6'd8;
                div_next = 4'h0;
                // host tracks its own permit; volatile permit does not set it
                if (reg_wdata[7:0] == OP_PERMIT_WRITE) begin
                  permit_next = 1'b1;
                end else if (reg_wdata[7:0] == OP_REVOKE_WRITE) begin
                  permit_next = 1'b0;
                end
              end
            end
          end
        end
        REG_ADDR: adr_next = reg_wdata[23:0];
        REG_LEN: len_next = reg_wdata[8:0];
        REG_WDATA: begin
          tx_next = reg_wdata[7:0];
          tx_full_next = 1'b1;
        end
        REG_LANES: lanes_next = reg_wdata[5:0];
        default: ;
      endcase
    end
    // serial engine
    if ((state_reg != FWC_IDLE) && (state_reg != FWC_END)) begin
      div_next = (div_reg == SCK_HALF) ? 4'h0 : div_reg + 4'h1;
      if (stall) begin
        div_next = div_reg;
      end else if (rise) begin
        sck_next = 1'b1;
      end else if (fall) begin
        sck_next = 1'b0;
        // sampled late in the high phase, so the synchroniser lag still lands inside the bit
        case (lane_mode)
          LANE_TWO: rx_sh_next = {rx_sh_reg[5:0], in_clean_reg[1:0]};
          LANE_FOUR: rx_sh_next = {rx_sh_reg[3:0], in_clean_reg};
          default: rx_sh_next = {rx_sh_reg[6:0], in_clean_reg[1]};
        endcase
      end
      // drive on the low phase start: shift out the top bits
      if (div_reg == 4'h0 && !sck_reg && !stall) begin
        if (state_reg == FWC_DATA && bits_reg == 6'd8 && !ctrl_reg[CTRL_READ] && tx_full_reg) begin
          sh_next = {tx_reg, 24'h000000};
          // a byte written in this very cycle stays pending
          tx_full_next = reg_wr && (reg_addr == REG_WDATA);
        end
        oe_next = 4'h0;
        out_next = 4'h0;
        if (!(state_reg == FWC_DATA && ctrl_reg[CTRL_READ]) && state_reg != FWC_DUMMY) begin
          case (lane_mode)
            LANE_TWO: begin
              out_next = {2'b00, sh_next[31:30]};
              oe_next = 4'h3;
            end
            LANE_FOUR: begin
              out_next = sh_next[31:28];
              oe_next = 4'hF;
            end
            default: begin
              out_next = {3'b000, sh_next[31]};
              oe_next = 4'h1;
            end
          endcase
        end
      end
      if (fall) begin
        sh_next = sh_reg << step;
        bits_next = bits_reg - {3'h0, step};
        if (bits_reg == {3'h0, step}) begin
          case (state_reg)
            FWC_CMD: begin
              if (ctrl_reg[CTRL_HAS_ADDR]) begin
                state_next = FWC_ADR;
                sh_next = {adr_reg, 8'h00};
                bits_next = ctrl_reg[CTRL_MODE_EN] ? 6'd32 : 6'd24;
              end else if (len_reg != 9'h000) begin
                state_next = FWC_DATA;
                bits_next = 6'd8;
              end else begin
                state_next = FWC_END;
              end
            end
            FWC_ADR: begin
              // dummy clock count set by software per command
              if (ctrl_reg[CTRL_DUMMY_LSB +: 4] != 4'h0) begin
                state_next = FWC_DUMMY;
                bits_next = {2'b00, ctrl_reg[CTRL_DUMMY_LSB +: 4]};
              end else begin
                state_next = (len_reg != 9'h000) ? FWC_DATA : FWC_END;
                bits_next = 6'd8;
              end
            end
            FWC_DUMMY: begin
              state_next = (len_reg != 9'h000) ? FWC_DATA : FWC_END;
              bits_next = 6'd8;
            end
            FWC_DATA: begin
              bits_next = 6'd8;
              if (ctrl_reg[CTRL_READ]) begin
                rx_next = rx_sh_next;
                rx_valid_next = 1'b1; // repeated status bytes read as they come
              end
              len_next = len_reg - 9'h001;
              if (len_reg == 9'h001) begin
                state_next = FWC_END;
              end
            end
            default: state_next = FWC_END;
          endcase
        end
      end
    end else if (state_reg == FWC_END) begin
      // select rises after last clock to commit the opcode
      sel_b_next = 1'b1;
      oe_next = 4'h0;
      state_next = FWC_IDLE;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= FWC_IDLE;
      ctrl_reg <= 32'h0000_0000;
      adr_reg <= 24'h000000;
      len_reg <= RESET_LEN;
      lanes_reg <= 6'h00;
      tx_reg <= 8'h00;
      tx_full_reg <= 1'b0;
      rx_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      rx_sh_reg <= 8'h00;
      sh_reg <= 32'h0000_0000;
      bits_reg <= 6'h00;
      div_reg <= 4'h0;
      sck_reg <= 1'b0;
      sel_b_reg <= 1'b1;
      out_reg <= 4'h0;
      oe_reg <= 4'h0;
      rdata_reg <= 32'h0000_0000;
      refused_reg <= 1'b0;
      permit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      adr_reg <= adr_next;
      len_reg <= len_next;
      lanes_reg <= lanes_next;
      tx_reg <= tx_next;
      tx_full_reg <= tx_full_next;
      rx_reg <= rx_next;
      rx_valid_reg <= rx_valid_next;
      rx_sh_reg <= rx_sh_next;
      sh_reg <= sh_next;
      bits_reg <= bits_next;
      div_reg <= div_next;
      sck_reg <= sck_next;
      sel_b_reg <= sel_b_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      rdata_reg <= rdata_next;
      refused_reg <= refused_next;
      permit_reg <= permit_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign flash_sel_b = sel_b_reg;
  assign flash_sck = sck_reg;
  assign io_line_out = out_reg;
  assign io_line_oe = oe_reg;
endmodule
`default_nettype wire

//--- logic/fwc_pkg.sv
/*
  package for the wide-line flash command host: opcodes, lane modes,
  controller register map and serial clock divider.
  assumes a single 100 MHz system clock domain.
*/
package fwc_pkg;
  // opcodes
  localparam logic [7:0] OP_PERMIT_WRITE = 8'h06;
  localparam logic [7:0] OP_VOLATILE_PERMIT = 8'h50;
  localparam logic [7:0] OP_REVOKE_WRITE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE_LO = 8'h01;
  localparam logic [7:0] OP_STATUS_WRITE_HI = 8'h31;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SET_READ_PARAM = 8'hC0;
  localparam logic [7:0] OP_WORD_READ_QIO = 8'hE7;
  localparam logic [7:0] OP_OCTAL_READ_QIO = 8'hE3;
  // lane modes of a phase
  localparam logic [1:0] LANE_ONE = 2'h0;
  localparam logic [1:0] LANE_TWO = 2'h1;
  localparam logic [1:0] LANE_FOUR = 2'h2;
  // controller registers (word index in low bits of address)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_LEN = 4'h2;
  localparam logic [3:0] REG_WDATA = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_LANES = 4'h6;
  // ctrl field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_HAS_ADDR = 8;
  localparam int CTRL_MODE_EN = 9;
  localparam int CTRL_READ = 10;
  localparam int CTRL_DUMMY_LSB = 12;
  localparam int CTRL_GO = 31;
  // lanes field positions: opcode, address, data
  localparam int LANES_CMD_LSB = 0;
  localparam int LANES_ADR_LSB = 2;
  localparam int LANES_DAT_LSB = 4;
  // status bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;
  localparam int STAT_RX_VALID = 2;
  localparam int STAT_TX_FULL = 3;
  localparam int STAT_PERMIT = 4;
  // serial clock: last divider count, so a half period lasts SCK_HALF + 1 system cycles
  localparam logic [3:0] SCK_HALF = 4'h2;
  localparam logic [8:0] MAX_PROGRAM_BYTES = 9'h100;
  localparam logic [8:0] RESET_LEN = 9'h000;
  localparam logic [3:0] RESET_DUMMY = 4'h0;
endpackage

//--- verification/fwc_host_chk.sv
/*
  checker for the wide-line flash host: serial clock shape, select,
  data line timing and register read port.
  assumes it is bound to fwc_host and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module fwc_host_chk
  import fwc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // flash pins
  input wire logic flash_sel_b,
  input wire logic flash_sck,
  input wire logic [3:0] io_line_out,
  input wire logic [3:0] io_line_oe,
  input wire logic [3:0] io_line_in
);
  logic go_bit;
  assign go_bit = reg_wdata[31];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_high3;
    flash_sck [*3] ##1 !flash_sck;
  endsequence
  sequence s_low3;
    !flash_sck [*3];
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_sck_high: assert property ($rose(flash_sck) |-> s_high3)
    else $error("serial clock high phase wrong");
  chk_sck_low: assert property ($fell(flash_sck) |-> s_low3)
    else $error("serial clock low phase too short");
  chk_sck_idle: assert property (flash_sel_b |-> !flash_sck)
    else $error("serial clock runs without select");
  chk_start_cause: assert property ($fell(flash_sel_b) |-> $past(reg_wr) && $past(go_bit) && $past(reg_addr) == REG_CTRL)
    else $error("select fell without a start write");
  chk_first_edge: assert property ($fell(flash_sel_b) |-> !flash_sck [*2])
    else $error("clock rose too soon after select");
  chk_out_stable: assert property ($rose(flash_sck) |=> $stable(io_line_out) [*2])
    else $error("data lines moved while clock high");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer");
  chk_oe_idle: assert property (flash_sel_b && $past(flash_sel_b) |-> io_line_oe == 4'h0)
    else $error("lines driven while deselected");
endmodule
bind fwc_host fwc_host_chk u_fwc_host_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flash_sel_b(flash_sel_b), .flash_sck(flash_sck),
  .io_line_out(io_line_out), .io_line_oe(io_line_oe), .io_line_in(io_line_in));
`default_nettype wire

//--- verification/fwc_dev_model.sv
/*
  behavioural flash device: write permit latch, status repeat, capture
  of command bits and a fixed repeating read byte.
  assumes the bench gives lane widths and header clock count.
*/
`timescale 1ns/1ps
`default_nettype none
module fwc_dev_model (
  // pins
  input wire logic sel_b,
  input wire logic sck,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  output logic [3:0] io_in,
  // set-up
  input wire logic [2:0] w_cap,
  input wire logic [2:0] w_drv,
  input wire logic [7:0] hdr,
  input wire logic [7:0] rd_byte,
  // observation
  output logic write_permit_latch,
  output logic [63:0] cap,
  output logic [7:0] clocks,
  output logic [7:0] writes
);
  logic [3:0] drv;
  logic [7:0] tx;
  logic [7:0] op;
  initial begin
    write_permit_latch = 1'b0;
    writes = 8'h00;
    op = 8'h00;
    cap = 64'h0;
    clocks = 8'h00;
    drv = 4'h5;
    tx = 8'h00;
  end
  // released lines show the inverse of the last value, not a kind constant
  assign io_in = (io_oe & io_out) | (~io_oe & drv);
  always @(negedge sel_b) begin
    clocks = 8'h00;
    cap = 64'h0;
    tx = rd_byte;
    op = 8'h00;
  end
  always @(posedge sck) if (!sel_b) begin
    case (w_cap)
      3'h1: cap = {cap[62:0], io_in[0]};
      3'h2: cap = {cap[61:0], io_in[1:0]};
      default: cap = {cap[59:0], io_in};
    endcase
    clocks++;
    if (int'(clocks) * int'(w_cap) == 8) op = cap[7:0];
    if (clocks == 8'h08 && cap[7:0] == 8'h05) tx = {6'h0, write_permit_latch, 1'b0};
  end
  // change mid low phase so the host synchroniser sees a long hold
  always @(negedge sck) if (!sel_b && clocks >= hdr) begin
    #15;
    case (w_drv)
      3'h1: drv = {4{tx[7]}};
      3'h2: drv = {2{tx[7:6]}};
      default: drv = tx[7:4];
    endcase
    if (w_drv == 3'h1) tx = {tx[6:0], tx[7]};
    else if (w_drv == 3'h2) tx = {tx[5:0], tx[7:6]};
    else tx = {tx[3:0], tx[7:4]};
  end
  always @(posedge sel_b) begin
    drv = ~drv;
    if (clocks == 8'h08 && cap[7:0] == 8'h06) write_permit_latch = 1'b1;
    if (clocks == 8'h08 && cap[7:0] == 8'h04) write_permit_latch = 1'b0;
    // program or erase runs only under the latch, and drops it when done
    if (op inside {8'h02, 8'h32, 8'h42, 8'h44, 8'h20}) begin
      if (write_permit_latch) writes++;
      write_permit_latch = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verification/fwc_host_tb.sv
/*
  testbench for the wide-line flash host with a device model.
  assumes the host register map and lane codes of fwc_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module fwc_host_tb;
  import fwc_pkg::*;
  logic clk_sys, rst_b, reg_wr, reg_rd, flash_sel_b, flash_sck, latch;
  logic [3:0] reg_addr, io_line_out, io_line_oe, io_line_in;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0] w_cap, w_drv;
  logic [7:0] hdr, rd_byte, clocks, writes;
  logic [63:0] cap;
  int errors, total_checks;
  fwc_host u_fwc_host (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_sel_b(flash_sel_b), .flash_sck(flash_sck), .io_line_out(io_line_out),
    .io_line_oe(io_line_oe), .io_line_in(io_line_in));
  fwc_dev_model u_fwc_dev_model (.sel_b(flash_sel_b), .sck(flash_sck),
    .io_out(io_line_out), .io_oe(io_line_oe), .io_in(io_line_in), .w_cap(w_cap),
    .w_drv(w_drv), .hdr(hdr), .rd_byte(rd_byte), .write_permit_latch(latch),
    .cap(cap), .clocks(clocks), .writes(writes));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic check(string name, logic [63:0] exp, logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_stat(int b, logic v);
    logic [31:0] s;
    int n;
    n = 0;
    rd(REG_STATUS, s);
    while (s[b] !== v && n < 500) begin
      rd(REG_STATUS, s);
      n++;
    end
    check("status bit", 64'(v), 64'(s[b]));
  endtask
  // a_on: bit 0 sends the address, bit 1 the mode bits after it
  task automatic go(logic [7:0] op, logic [1:0] a_on, logic rd_on, logic [3:0] dum,
    logic [23:0] adr, logic [8:0] len, logic [1:0] lc, logic [1:0] ld);
    w_cap = 3'h1 << lc;
    w_drv = 3'h1 << ld;
    hdr = 8'(8 / w_cap + (a_on[0] ? 24 / w_cap : 0) + (a_on[1] ? 8 / w_cap : 0) + dum);
    wr(REG_ADDR, {8'h00, adr});
    wr(REG_LEN, {23'h0, len});
    wr(REG_LANES, {26'h0, ld, lc, lc});
    wr(REG_CTRL, {1'b1, 15'h0, dum, 1'b0, rd_on, a_on, op});
  endtask
  task automatic run(logic [7:0] op);
    go(op, 1'b0, 1'b0, 4'h0, 24'h0, 9'h000, 2'h0, 2'h0);
    wait_stat(STAT_BUSY, 1'b0);
    repeat (4) @(posedge clk_sys);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("select idle", 64'h1, 64'(flash_sel_b));
    check("clock idle", 64'h0, 64'(flash_sck));
    check("drive idle", 64'h0, 64'(io_line_oe));
  endtask
  task automatic t_latch();
    logic [31:0] d;
    run(8'h06);
    check("latch set", 64'h1, 64'(latch));
    wait_stat(STAT_PERMIT, 1'b1);
    check("opcode bits", 64'h06, cap);
    run(8'h50);
    check("latch kept", 64'h1, 64'(latch));
    go(8'h05, 1'b0, 1'b1, 4'h0, 24'h0, 9'h003, 2'h0, 2'h0);
    for (int i = 0; i < 3; i++) begin
      wait_stat(STAT_RX_VALID, 1'b1);
      rd(REG_RDATA, d);
      check("status repeat", 64'h02, 64'(d[7:0]));
    end
    wait_stat(STAT_BUSY, 1'b0);
    run(8'h04);
    check("latch clear", 64'h0, 64'(latch));
    wait_stat(STAT_PERMIT, 1'b0);
  endtask
  task automatic t_lanes();
    for (int l = 0; l < 3; l++) begin
      go(8'h0B, 1'b1, 1'b0, 4'h0, 24'h5AC31E, 9'h000, 2'(l), 2'(l));
      wait_stat(STAT_BUSY, 1'b0);
      check("opcode address", 64'h0B5AC31E, cap);
      check("clock count", 64'(32 >> l), 64'(clocks));
    end
  endtask
  task automatic t_read();
    logic [31:0] d;
    for (int l = 0; l < 3; l++) begin
      go(8'hEB, 2'h3, 1'b1, 4'h4, 24'h012340, 9'h002, 2'h0, 2'(l));
      for (int i = 0; i < 2; i++) begin
        wait_stat(STAT_RX_VALID, 1'b1);
        rd(REG_RDATA, d);
        check("read byte", 64'hC6, 64'(d[7:0]));
      end
      wait_stat(STAT_BUSY, 1'b0);
    end
  endtask
  task automatic t_refuse();
    logic [31:0] s;
    logic [7:0] op [5] = '{8'h02, 8'h02, 8'h44, 8'hE7, 8'hE3};
    logic [23:0] ad [5] = '{24'h0, 24'h0, 24'h000400, 24'h000001, 24'h000008};
    logic [8:0] ln [5] = '{9'h000, 9'h101, 9'h000, 9'h001, 9'h001};
    for (int i = 0; i < 5; i++) begin
      go(op[i], 1'b1, op[i][7], 4'h0, ad[i], ln[i], 2'h0, 2'h0);
      rd(REG_STATUS, s);
      check("refused flag", 64'h1, 64'(s[STAT_REFUSED]));
      check("no frame", 64'h1, 64'(flash_sel_b));
    end
    go(8'h44, 1'b1, 1'b0, 4'h0, 24'h000300, 9'h000, 2'h0, 2'h0);
    wait_stat(STAT_BUSY, 1'b0);
    check("sector address", 64'h44000300, cap);
    check("erase ignored", 64'h0, 64'(writes));
  endtask
  task automatic t_write();
    run(8'h06);
    go(8'h02, 1'b1, 1'b0, 4'h0, 24'h000010, 9'h002, 2'h2, 2'h2);
    wr(REG_WDATA, 32'h0000_00A5);
    wait_stat(STAT_TX_FULL, 1'b0);
    wr(REG_WDATA, 32'h0000_003C);
    wait_stat(STAT_BUSY, 1'b0);
    repeat (2) @(posedge clk_sys);
    check("program frame", 64'h0200_0010_A53C, cap);
    check("latch dropped", 64'h0, 64'(latch));
    check("program taken", 64'h1, 64'(writes));
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // whole run needs well under a tenth of this span
  initial begin
    #1000000;
    errors++;
    print_verdict();
  end
  initial begin
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    w_cap = 3'h1;
    w_drv = 3'h1;
    hdr = 8'h08;
    rd_byte = 8'hC6;
    errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_latch();
    t_lanes();
    t_read();
    t_refuse();
    t_write();
    print_verdict();
  end
endmodule
`default_nettype wire
